// File: src/acs_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register byte offsets, one aligned word each
`define ACS_OFF_CTRL0     8'h00
`define ACS_OFF_CTRL1     8'h04
`define ACS_OFF_SLOT0     8'h08
`define ACS_OFF_SLOT1     8'h0C
`define ACS_OFF_START     8'h10
`define ACS_OFF_STATUS    8'h14
`define ACS_OFF_ICLR      8'h18
`define ACS_OFF_MASK      8'h1C
`define ACS_OFF_RESULT    8'h20
`define ACS_RESULT_MASK   8'hE0

// Control register zero fields
`define ACS_CTRL0_EN      0
`define ACS_CTRL0_MODE_LO 1
`define ACS_CTRL0_MODE_HI 3
`define ACS_CTRL0_SPEED   4
`define ACS_CTRL0_TRIGEN  5

// Slot configuration zero: length in [2:0], slots 0..3 in [19:4]
`define ACS_SLOT0_LEN_HI  2
`define ACS_SLOT0_CH_LO   4
`define ACS_SLOT0_CH_HI   19

// Status, clear and mask bit positions
`define ACS_ST_CONV       0
`define ACS_ST_SEQ        1
`define ACS_ST_READY      2

// Mode codes of the two continuous modes
`define ACS_MODE_SINGLE   3'h2
`define ACS_MODE_SEQ      3'h3

// Reset values
`define ACS_MODE_RST      3'h0
`define ACS_MASK_RST      2'h0

// Start-up time of the converter after power-on
`define ACS_STARTUP_NS    2000
`define ACS_CLK_MHZ       100
`define ACS_STARTUP_CYC   ((`ACS_STARTUP_NS * `ACS_CLK_MHZ + 999) / 1000)

`endif

// File: src/acs_pkg.sv
// Types shared by the continuous conversion sequencer
package acs_pkg;
    typedef logic [31:0] acs_word_t;
    typedef logic [11:0] acs_result_t;
    typedef logic [3:0]  acs_chan_t;
    typedef logic [2:0]  acs_slot_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CONV  = 2'b01,
        ST_DRAIN = 2'b10
    } acs_state_e;
endpackage

// File: src/acs_sync.sv
// Two-stage synchroniser for levels that arrive from outside the clock
`timescale 1ns/1ns
module acs_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk, // System clock
    input  wire logic         nrst,    // Async reset, active low
    input  wire logic [W-1:0] asyncIn, // Unsynchronised levels
    output logic      [W-1:0] syncOut  // Levels after two flops
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule // acs_sync

// File: src/acs_result_mem.sv
// Eight result words with one write port and a registered read port
`timescale 1ns/1ns
module acs_result_mem (
    input  wire logic                ref_clk, // System clock
    input  wire logic                nrst,    // Async reset, active low
    input  wire logic                wrEn,    // Write strobe
    input  wire acs_pkg::acs_slot_t  wrAddr,  // Write index
    input  wire acs_pkg::acs_result_t wrData, // Write data
    input  wire acs_pkg::acs_slot_t  rdAddr,  // Read index
    output acs_pkg::acs_result_t     rdData   // Read data, registered
);
    import acs_pkg::*;

    acs_result_t mem_q [8];

    // Storage; reset so that results never read as unknown
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wrEn) begin
            mem_q[wrAddr] <= wrData;
        end
    end

    // Registered read; a write to the same index shows a cycle later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= '0;
        end else begin
            rdData <= mem_q[rdAddr];
        end
    end
endmodule // acs_result_mem

// File: src/acs_top.sv
// Continuous conversion sequencer with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "acs_params.svh"

// How it works
// - Single-channel mode repeats one channel until software clears start
// - Each finished conversion sets the conversion flag and stores a result
// - A written zero to start or a cleared enable stops the run; no new conversion is launched
// - Eight slots, each picking one of sixteen input channels
// - Length field N converts slots 0 through N
// - Sequence mode repeats the selected slots until start is cleared
// - A slot's result lands in the result register of the same index
// - The end of each pass sets the sequence flag
// - Clearing enable clears start and powers the converter down on the same edge
module acs_top (
    input  wire logic                ref_clk,     // System clock, 100 MHz
    input  wire logic                nrst,        // Async reset, active low
    input  wire logic                hsel,        // AHB slave select
    input  wire logic [31:0]         haddr,       // AHB address
    input  wire logic [1:0]          htrans,      // AHB transfer type
    input  wire logic                hwrite,      // AHB write
    input  wire logic [2:0]          hsize,       // AHB size, words only
    input  wire acs_pkg::acs_word_t  hwdata,      // AHB write data
    input  wire logic                hready,      // AHB bus ready
    output acs_pkg::acs_word_t       hrdata,      // AHB read data
    output logic                     hreadyout,   // AHB slave ready
    output logic                     hresp,       // AHB response, OKAY
    input  wire logic                extTrig,     // External start trigger
    input  wire logic                convDone,    // Converter result valid
    input  wire acs_pkg::acs_result_t convData,   // Converter result
    output logic                     convReq,     // Conversion request
    output acs_pkg::acs_chan_t       convChannel, // Channel to convert
    output logic                     powerOn,     // Converter powered
    output logic                     sampleSpeed, // Sampling speed select
    output logic                     irq          // Interrupt, level
);
    import acs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Channel for the slot in use, in either continuous mode
    function automatic acs_chan_t chanFor(input logic [2:0] mode,
                                          input acs_slot_t slot,
                                          input logic [31:0] slots,
                                          input acs_chan_t single);
        if (mode == `ACS_MODE_SEQ) begin
            chanFor = slots[{slot, 2'b00} +: 4];
        end else begin
            chanFor = single;
        end
    endfunction

    // Next slot of a pass, wrapping after the last selected one
    function automatic acs_slot_t nextSlot(input acs_slot_t slot,
                                           input acs_slot_t len);
        nextSlot = (slot == len) ? 3'h0 : 3'(slot + 3'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic        trigS, doneS, trigDly_q, trigEdge;    // Trigger and done path
    acs_result_t dataS, memRd;                         // Result words
    logic        accPend_q, accWrite_q, wrStb, rdStb;  // Bus data phase
    logic [7:0]  accAddr_q;
    logic [31:0] slotCh_q, rdMux;
    logic        enable_q, trigEn_q, start_q, ready_q;
    logic [2:0]  mode_q;
    acs_chan_t   chanSel_q, expChan;
    acs_slot_t   seqLen_q, slot_q, memWaddr;
    logic [1:0]  stat_q, stat_d, mask_q;
    logic [8:0]  upCnt_q;
    acs_state_e  state_q;
    logic        modeCont, runOk, finish, passEnd, memWe;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins from the trigger source and the converter
    acs_sync #(.W(14)) uSync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .asyncIn ({extTrig, convDone, convData}),
        .syncOut ({trigS, doneS, dataS})
    );

    // Trigger edge compares the synced level with its delayed copy
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trigDly_q <= 1'b0;
        end else begin
            trigDly_q <= trigS;
        end
    end

    assign trigEdge = trigS && !trigDly_q && trigEn_q;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: one wait state on every transfer
    // Address phase captured; data phase takes two cycles so the
    // registered result memory can answer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            accPend_q  <= 1'b0;
            accWrite_q <= 1'b0;
            accAddr_q  <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else if (accPend_q) begin
            accPend_q <= 1'b0;
            hreadyout <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            accPend_q  <= 1'b1;
            accWrite_q <= hwrite;
            accAddr_q  <= {haddr[7:2], 2'b00};
            hreadyout  <= 1'b0;
        end
    end

    assign wrStb = accPend_q && accWrite_q;
    assign rdStb = accPend_q && !accWrite_q;

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rdMux = 32'h0000_0000;
        if ((accAddr_q & `ACS_RESULT_MASK) == `ACS_OFF_RESULT) begin
            rdMux = {20'h0_0000, memRd};
        end else begin
            unique case (accAddr_q)
                `ACS_OFF_CTRL0:  rdMux = {26'h000_0000, trigEn_q,
                                          sampleSpeed, mode_q, enable_q};
                `ACS_OFF_CTRL1:  rdMux = {28'h000_0000, chanSel_q};
                `ACS_OFF_SLOT0:  rdMux = {12'h000, slotCh_q[15:0],
                                          1'b0, seqLen_q};
                `ACS_OFF_SLOT1:  rdMux = {16'h0000, slotCh_q[31:16]};
                `ACS_OFF_START:  rdMux = {31'h0000_0000, start_q};
                `ACS_OFF_STATUS: rdMux = {29'h0000_0000, ready_q, stat_q};
                `ACS_OFF_MASK:   rdMux = {30'h0000_0000, mask_q};
                default:         rdMux = 32'h0000_0000;
            endcase
        end
    end

    // Read data registered at the end of the first data-phase cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (rdStb) begin
            hrdata <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    // Mode, speed, trigger enable, channel and slot setup
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q    <= 1'b0;
            mode_q      <= `ACS_MODE_RST;
            sampleSpeed <= 1'b0;
            trigEn_q    <= 1'b0;
            chanSel_q   <= 4'h0;
            seqLen_q    <= 3'h0;
            slotCh_q    <= 32'h0000_0000;
            mask_q      <= `ACS_MASK_RST;
        end else if (wrStb) begin
            unique case (accAddr_q)
                `ACS_OFF_CTRL0: begin
                    enable_q    <= hwdata[`ACS_CTRL0_EN];
                    mode_q      <= hwdata[`ACS_CTRL0_MODE_HI:
                                          `ACS_CTRL0_MODE_LO];
                    sampleSpeed <= hwdata[`ACS_CTRL0_SPEED];
                    trigEn_q    <= hwdata[`ACS_CTRL0_TRIGEN];
                end
                `ACS_OFF_CTRL1: chanSel_q <= hwdata[3:0];
                `ACS_OFF_SLOT0: begin
                    seqLen_q        <= hwdata[`ACS_SLOT0_LEN_HI:0];
                    slotCh_q[15:0]  <= hwdata[`ACS_SLOT0_CH_HI:
                                              `ACS_SLOT0_CH_LO];
                end
                `ACS_OFF_SLOT1: slotCh_q[31:16] <= hwdata[15:0];
                `ACS_OFF_MASK:  mask_q <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Converter power follows the enable bit from a flop, one cycle behind
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            powerOn <= 1'b0;
        end else begin
            powerOn <= enable_q;
        end
    end

    // Ready after the start-up time; lost as soon as power is removed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            upCnt_q <= 9'h000;
            ready_q <= 1'b0;
        end else if (!enable_q) begin
            upCnt_q <= 9'h000;
            ready_q <= 1'b0;
        end else if (upCnt_q == 9'(`ACS_STARTUP_CYC)) begin
            ready_q <= 1'b1;
        end else begin
            upCnt_q <= 9'(upCnt_q + 9'h001);
        end
    end

    // Start bit: trigger or software sets it, only software clears it;
    // a trigger in the same cycle as a clearing write wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 1'b0;
        end else if (!enable_q) begin
            start_q <= 1'b0;
        end else if (trigEdge) begin
            start_q <= 1'b1;
        end else if (wrStb && accAddr_q == `ACS_OFF_START) begin
            start_q <= hwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    assign modeCont = (mode_q == `ACS_MODE_SINGLE) ||
                      (mode_q == `ACS_MODE_SEQ);
    assign runOk    = start_q && enable_q && ready_q && modeCont;
    assign finish   = (state_q == ST_CONV) && doneS;
    assign passEnd  = finish && (mode_q == `ACS_MODE_SEQ) &&
                      (slot_q == seqLen_q);
    assign expChan  = chanFor(mode_q, slot_q, slotCh_q, chanSel_q);

    // Request held until the converter answers, then released and the
    // answer allowed to drop before the next launch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= ST_IDLE;
            convReq     <= 1'b0;
            convChannel <= 4'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (runOk) begin
                        convReq     <= 1'b1;
                        convChannel <= expChan;
                        state_q     <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (doneS) begin
                        convReq <= 1'b0;
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (!doneS) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    convReq <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Slot pointer climbs from zero and wraps; parked at zero when idle with start clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            slot_q <= 3'h0;
        end else if (!start_q && state_q == ST_IDLE) begin
            slot_q <= 3'h0;
        end else if (finish && mode_q == `ACS_MODE_SEQ) begin
            slot_q <= nextSlot(slot_q, seqLen_q);
        end
    end

    // Results go to the slot's own register, or to zero in single mode
    assign memWe    = finish;
    assign memWaddr = (mode_q == `ACS_MODE_SEQ) ? slot_q : 3'h0;

    acs_result_mem uMem (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .wrEn    (memWe),
        .wrAddr  (memWaddr),
        .wrData  (dataS),
        .rdAddr  (haddr[4:2]),
        .rdData  (memRd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky status and interrupt
    // Read of status or a zero written to the clear register clears a
    // flag; a new event in the same cycle still sets it
    always_comb begin
        stat_d = stat_q;
        if (rdStb && accAddr_q == `ACS_OFF_STATUS) begin
            stat_d = 2'h0;
        end
        if (wrStb && accAddr_q == `ACS_OFF_ICLR) begin
            stat_d = stat_d & hwdata[1:0];
        end
        if (finish) begin
            stat_d[`ACS_ST_CONV] = 1'b1;
        end
        if (passEnd) begin
            stat_d[`ACS_ST_SEQ] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Interrupt from a flop, one cycle behind the status bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_NO_LAUNCH_STOPPED: assert property (@(posedge ref_clk)
        disable iff (!nrst) (state_q == ST_IDLE && !start_q) |=> !convReq)
        else $error("conversion launched with start clear");
    AST_RELAUNCH: assert property (@(posedge ref_clk)
        disable iff (!nrst) (state_q == ST_IDLE && runOk)
        |=> (convReq && state_q == ST_CONV))
        else $error("running sequencer failed to launch");
    AST_CONV_FLAG: assert property (@(posedge ref_clk)
        disable iff (!nrst) finish |=> stat_q[`ACS_ST_CONV])
        else $error("conversion flag not set after completion");
    AST_SEQ_FLAG: assert property (@(posedge ref_clk)
        disable iff (!nrst) passEnd |=> stat_q[`ACS_ST_SEQ])
        else $error("sequence flag not set at pass end");
    AST_WRAP: assert property (@(posedge ref_clk)
        disable iff (!nrst) (passEnd && start_q) |=> (slot_q == 3'h0))
        else $error("slot did not wrap to zero");
    AST_SINGLE_CHAN: assert property (@(posedge ref_clk)
        disable iff (!nrst) ($rose(convReq) && $past(mode_q) ==
        `ACS_MODE_SINGLE) |-> (convChannel == $past(chanSel_q)))
        else $error("single mode converted a wrong channel");
    AST_SLOT_CHAN: assert property (@(posedge ref_clk)
        disable iff (!nrst) $rose(convReq) |-> convChannel == $past(expChan))
        else $error("slot channel mismatch at launch");
    AST_RESULT_SLOT: assert property (@(posedge ref_clk)
        disable iff (!nrst) (memWe && mode_q != `ACS_MODE_SEQ)
        |-> (memWaddr == 3'h0))
        else $error("single mode result not in register zero");
    AST_POWER_STOP: assert property (@(posedge ref_clk)
        disable iff (!nrst) !enable_q |=> (!start_q && !powerOn))
        else $error("start or power held while disabled");
endmodule // acs_top

// File: tb/acs_conv_model.sv
// Behavioural converter that answers the sequencer's request handshake
`timescale 1ns/1ns
module acs_conv_model (
    input  wire logic               ref_clk,     // System clock
    input  wire logic               nrst,        // Reset, active low
    input  wire logic               convReq,     // Request level
    input  wire acs_pkg::acs_chan_t convChannel, // Channel asked for
    input  wire logic [2:0]         dly,         // Extra answer cycles
    output logic                    convDone,    // Result valid
    output acs_pkg::acs_result_t    convData     // Result word
);
    import acs_pkg::*;
    logic [2:0] waitQ;
    // Answer dly+1 cycles after the request rises and hold until it drops; released
    // data turn over so a stale word never looks like a fresh result
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            convDone <= 1'b0;
            convData <= 12'h000;
            waitQ    <= 3'h0;
        end else if (convReq && !convDone) begin
            waitQ <= waitQ + 3'h1;
            if (waitQ >= dly) begin
                convDone <= 1'b1;
                convData <= {~convChannel, 4'h5, convChannel};
            end
        end else if (!convReq && convDone) begin
            convDone <= 1'b0;
            convData <= ~convData;
            waitQ    <= 3'h0;
        end
    end
endmodule // acs_conv_model

// File: tb/adc_continuous_sequencer_tb.sv
// Self-checking bench for the continuous conversion sequencer
`timescale 1ns/1ns
`include "acs_params.svh"
module adc_continuous_sequencer_tb;
    import acs_pkg::*;
    logic        ref_clk = 1'b0, nrst = 1'b0, hsel = 1'b0;
    logic        hwrite = 1'b0, extTrig = 1'b0, reqQ = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  dly = 3'h0;
    acs_word_t   hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, convDone, convReq, powerOn;
    logic        sampleSpeed, irq;
    acs_result_t convData;
    acs_chan_t   convChannel, ch[8], chLog[$];
    int          seed = 93314, err_total = 0, total_checks = 0;

    always #5 ref_clk = ~ref_clk;

    // Only word transfers exist, so the size is tied
    acs_top i_dut (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .extTrig, .convDone, .convData, .convReq, .convChannel,
        .powerOn, .sampleSpeed, .irq);
    acs_conv_model i_model (.ref_clk, .nrst, .convReq, .convChannel,
        .dly, .convDone, .convData);

    // Log the channel of each new request in launch order
    always @(posedge ref_clk) begin
        reqQ <= convReq;
        if (convReq === 1'b1 && reqQ !== 1'b1) chLog.push_back(convChannel);
    end

    function automatic acs_word_t conv_val(input acs_chan_t c);
        return {20'h0, ~c, 4'h5, c};
    endfunction
    task automatic check(input acs_word_t seenV, input acs_word_t exp);
        total_checks++;
        if (seenV !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seenV, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Wait for hready high at an edge; a stuck slave ends the run
    task automatic busWait;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input acs_word_t d, output acs_word_t r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        busWait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        busWait();
        r = hrdata;
        check(hresp, 1'b0);
    endtask
    // Trigger pin high for four edges, then time for the synced edge
    task automatic pulseTrig;
        extTrig <= 1'b1;
        repeat (4) @(posedge ref_clk);
        extTrig <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input acs_word_t d);
        ahb(1'b1, a, d, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input acs_word_t e);
        ahb(1'b0, a, 32'h0, rd);
        check(rd, e);
    endtask
    task automatic waitLog(input int cnt);
        int n;
        for (n = 0; n < 4000 && chLog.size() < cnt; n++) @(posedge ref_clk);
        if (chLog.size() < cnt) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // Clear start, let the request in flight finish, then expect silence
    task automatic stopRun;
        int n, s;
        wr(`ACS_OFF_START, 32'h0);
        for (n = 0; n < 200 && convReq !== 1'b0; n++) @(posedge ref_clk);
        s = chLog.size();
        repeat (60) @(posedge ref_clk);
        check(chLog.size(), s);
        check(convReq, 1'b0);
    endtask

    initial begin
        int len, k, p;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        check(irq, 1'b0);
        rdchk(`ACS_OFF_STATUS, 32'h0);
        rdchk(8'h40, 32'h0);
        rdchk(`ACS_OFF_ICLR, 32'h0);
        // Enable and poll ready before choosing a mode
        wr(`ACS_OFF_CTRL0, 32'h1);
        rd = 32'h0;
        for (k = 0; k < 200 && rd[`ACS_ST_READY] !== 1'b1; k++)
            ahb(1'b0, `ACS_OFF_STATUS, 32'h0, rd);
        check(rd, 32'h4);
        check(powerOn, 1'b1);
        // Single channel run, conversion flag masked in
        ch[0] = 4'($random(seed));
        dly <= 3'($random(seed));
        wr(`ACS_OFF_CTRL1, {28'h0, ch[0]});
        wr(`ACS_OFF_MASK, 32'h1);
        wr(`ACS_OFF_CTRL0, 32'h15);
        chLog.delete();
        wr(`ACS_OFF_START, 32'h1);
        waitLog(4);
        check(sampleSpeed, 1'b1);
        check(irq, 1'b1);
        rdchk(`ACS_OFF_RESULT, conv_val(ch[0]));
        rdchk(`ACS_OFF_STATUS, 32'h5);
        stopRun();
        for (k = 0; k < chLog.size(); k++) check(chLog[k], ch[0]);
        // Sequence runs: shortest, longest, then random lengths
        for (p = 0; p < 4; p++) begin
            len = (p == 0) ? 0 : (p == 1) ? 7 : ($random(seed) & 7);
            for (k = 0; k < 8; k++) ch[k] = 4'($random(seed));
            dly <= 3'($random(seed));
            wr(`ACS_OFF_SLOT0, {12'h0, ch[3], ch[2], ch[1], ch[0],
                                1'b0, 3'(len)});
            wr(`ACS_OFF_SLOT1, {16'h0, ch[7], ch[6], ch[5], ch[4]});
            wr(`ACS_OFF_ICLR, 32'h0);
            wr(`ACS_OFF_MASK, {30'h0, p[0], 1'b0});
            wr(`ACS_OFF_CTRL0, 32'h27);
            chLog.delete();
            if (p[0]) pulseTrig();
            else wr(`ACS_OFF_START, 32'h1);
            waitLog(2 * len + 3);
            stopRun();
            for (k = 0; k < chLog.size(); k++)
                check(chLog[k], ch[k % (len + 1)]);
            check(irq, p[0]);
            rdchk(`ACS_OFF_STATUS, 32'h7);
            for (k = 0; k <= len; k++)
                rdchk(8'(`ACS_OFF_RESULT + 4 * k), conv_val(ch[k]));
            check(irq, 1'b0);
        end
        // An idle mode code never launches although a trigger sets start;
        // with the trigger disabled the pin is ignored
        chLog.delete();
        wr(`ACS_OFF_CTRL0, 32'h21);
        pulseTrig();
        repeat (40) @(posedge ref_clk);
        check(chLog.size(), 0);
        rdchk(`ACS_OFF_START, 32'h1);
        wr(`ACS_OFF_START, 32'h0);
        wr(`ACS_OFF_CTRL0, 32'h1);
        pulseTrig();
        rdchk(`ACS_OFF_START, 32'h0);
        // Power down once stopped
        wr(`ACS_OFF_CTRL0, 32'h0);
        repeat (2) @(posedge ref_clk);
        check(powerOn, 1'b0);
        rdchk(`ACS_OFF_STATUS, 32'h0);
        report_and_stop();
    end
endmodule // adc_continuous_sequencer_tb
